/* rtl/dpb_port_ctl.sv */
// Host controller for one port of the dual-port memory.
// Drives select, semaphore select, strobe, output enable and data; samples busy.
// Assumes all pin inputs are synchronous to CLOCK_I.
`timescale 1ns/1ps
module dpb_port_ctl
  import dpb_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic REQ_I,
  input wire logic REQ_WRITE_I,
  input wire logic REQ_SEM_I,
  input wire logic REQ_OE_LOW_I,
  input wire logic [AW-1:0] REQ_ADDR_I,
  input wire logic [DW-1:0] REQ_WDATA_I,
  input wire logic MASTER_I,
  input wire logic BUSY_N_I,
  input wire logic [DW-1:0] DATA_I,
  output logic READY_O,
  output logic DONE_O,
  output logic [DW-1:0] RDATA_O,
  output logic SEM_GRANT_O,
  output logic CHIP_SEL_N_O,
  output logic SEMAPHORE_SELECT_N_O,
  output logic WRITE_N_O,
  output logic OUT_EN_N_O,
  output logic [AW-1:0] ADDR_O,
  output logic [DW-1:0] DATA_O,
  output logic DATA_OE_O
);
  dpb_state_t state_q;
  logic wr_q, sem_q, oe_lo_q, was_busy_q;
  dpb_cnt_if cnt();
  dpb_timer u_tmr (.clk_i(CLOCK_I), .rst_i(RST_I), .cnt(cnt.tmr));

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n - 1);
  endfunction

  // Busy seen while strobe is low: the write is not complete until release
  wire busy_low = !BUSY_N_I;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= DPB_IDLE;
      wr_q <= 1'b0;
      sem_q <= 1'b0;
      oe_lo_q <= 1'b0;
      was_busy_q <= 1'b0;
    end else begin
      unique case (state_q)
        DPB_IDLE: begin
          if (REQ_I) begin
            wr_q <= REQ_WRITE_I;
            sem_q <= REQ_SEM_I;
            oe_lo_q <= REQ_OE_LOW_I && REQ_WRITE_I;
            was_busy_q <= 1'b0;
            state_q <= DPB_SETUP;
          end
        end
        DPB_SETUP: begin
          if (cnt.done) begin
            state_q <= wr_q ? DPB_PULSE : DPB_READ;
          end
        end
        DPB_PULSE: begin
          if (busy_low) begin
            was_busy_q <= 1'b1;
          end
          if (cnt.done && !busy_low) begin
            state_q <= was_busy_q ? DPB_HOLD : (sem_q ? DPB_SWRD : DPB_RECOV);
          end
        end
        DPB_HOLD: begin
          if (cnt.done) begin
            state_q <= sem_q ? DPB_SWRD : DPB_RECOV;
          end
        end
        DPB_SWRD: begin
          if (cnt.done) begin
            state_q <= DPB_READ;
          end
        end
        DPB_READ: begin
          if (busy_low) begin
            was_busy_q <= 1'b1;
          end
          if (cnt.done && !busy_low) begin
            state_q <= DPB_RECOV;
          end
        end
        DPB_RECOV: begin
          if (cnt.done) begin
            state_q <= DPB_IDLE;
          end
        end
      endcase
    end
  end

  // Phase timer loads
  always_comb begin
    cnt.load = 1'b0;
    cnt.value = '0;
    unique case (state_q)
      DPB_IDLE: begin
        cnt.load = REQ_I;
        cnt.value = cyc(AS_CYC);
      end
      DPB_SETUP: begin
        cnt.load = cnt.done;
        cnt.value = wr_q ? (oe_lo_q ? cyc(WP_OE_CYC) : cyc(WP_CYC)) : cyc(RD_CYC);
      end
      DPB_PULSE: begin
        cnt.load = cnt.done && !busy_low;
        cnt.value = was_busy_q ? cyc(WH_CYC) : (sem_q ? cyc(SWRD_CYC) : cyc(WR_CYC));
      end
      DPB_HOLD: begin
        cnt.load = cnt.done;
        cnt.value = sem_q ? cyc(SWRD_CYC) : cyc(WR_CYC);
      end
      DPB_SWRD: begin
        cnt.load = cnt.done;
        cnt.value = cyc(RD_CYC);
      end
      DPB_READ: begin
        // Busy seen on a read: wait the data-valid delay after release
        cnt.load = busy_low;
        cnt.value = cyc(BDD_CYC);
      end
      DPB_RECOV: begin
        cnt.load = 1'b0;
        cnt.value = '0;
      end
    endcase
  end

  // Pin drive: select combination held across whole access; address only moves in idle
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      CHIP_SEL_N_O <= 1'b1;
      SEMAPHORE_SELECT_N_O <= 1'b1;
      ADDR_O <= '0;
    end else if (state_q == DPB_IDLE && REQ_I) begin
      ADDR_O <= REQ_ADDR_I;
      CHIP_SEL_N_O <= REQ_SEM_I;
      SEMAPHORE_SELECT_N_O <= !REQ_SEM_I;
    end else if (state_q == DPB_RECOV && cnt.done) begin
      CHIP_SEL_N_O <= 1'b1;
      SEMAPHORE_SELECT_N_O <= 1'b1;
    end
  end

  // Strobe low only after select has settled, rising before select rises
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      WRITE_N_O <= 1'b1;
      OUT_EN_N_O <= 1'b1;
      DATA_OE_O <= 1'b0;
      DATA_O <= '0;
    end else begin
      WRITE_N_O <= !((state_q == DPB_SETUP && cnt.done && wr_q) ||
                     (state_q == DPB_PULSE && !(cnt.done && !busy_low && !was_busy_q)) ||
                     (state_q == DPB_HOLD && !cnt.done));
      // Data driven only while memory outputs are off
      DATA_OE_O <= wr_q && (state_q == DPB_SETUP || state_q == DPB_PULSE || state_q == DPB_HOLD) &&
                   !(state_q == DPB_SETUP && oe_lo_q);
      OUT_EN_N_O <= !((state_q == DPB_IDLE && REQ_I && !REQ_WRITE_I) || state_q == DPB_READ ||
                      (state_q == DPB_SWRD && cnt.done) ||
                      (state_q == DPB_IDLE && REQ_I && REQ_OE_LOW_I));
      if (state_q == DPB_IDLE && REQ_I) begin
        DATA_O <= REQ_WDATA_I;
      end
    end
  end

  // Handshake outputs
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      READY_O <= 1'b1;
      DONE_O <= 1'b0;
      RDATA_O <= '0;
      SEM_GRANT_O <= 1'b0;
    end else begin
      READY_O <= (state_q == DPB_IDLE && !REQ_I) || (state_q == DPB_RECOV && cnt.done);
      DONE_O <= state_q == DPB_RECOV && cnt.done;
      if (state_q == DPB_READ && cnt.done && !busy_low) begin
        RDATA_O <= DATA_I;
        if (sem_q) begin
          SEM_GRANT_O <= !DATA_I[0];
        end
      end
    end
  end

  // Slave busy is an input; in master mode it is the device's own flag, same handling
  wire unused_mode = MASTER_I;

  a_strobe_sel: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !WRITE_N_O |-> (CHIP_SEL_N_O != SEMAPHORE_SELECT_N_O)) else $error("strobe without one select");
  a_addr_stable: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (ADDR_O != $past(ADDR_O)) |-> ($past(WRITE_N_O) && $past(CHIP_SEL_N_O))) else $error("address moved");
  a_busy_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (state_q == DPB_PULSE && busy_low) |=> !WRITE_N_O) else $error("strobe dropped under busy");
  sequence s_release;
    state_q == DPB_PULSE && was_busy_q && !busy_low && cnt.done;
  endsequence
  a_write_hold: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_release |=> !WRITE_N_O [*3]) else $error("write hold short");
  a_no_contend: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    DATA_OE_O |-> OUT_EN_N_O) else $error("bus fight");
  a_sem_keep: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (sem_q && state_q == DPB_SWRD) |-> CHIP_SEL_N_O) else $error("select dropped in semaphore");
  a_stretch: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $fell(WRITE_N_O) && oe_lo_q |-> !WRITE_N_O [*4]) else $error("pulse not stretched");
  a_ready_idle: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    READY_O |-> CHIP_SEL_N_O || state_q == DPB_IDLE) else $error("ready while busy");
endmodule

/* rtl/dpb_pkg.sv */
// Constants and types for the dual-port memory port controller (host side).
// Assumes one 200 MHz clock and pins sampled synchronously to it.
// Contract
// - Host keeps strobe or select high whenever address lines change.
// - Array needs select low, semaphore high; semaphore the reverse; held whole write.
// - Host never drives data while the memory drives its pins.
// - With output enable low, host stretches write pulse for driver turn-off.
// - Host keeps select high through semaphore write and read-back.
// - Slave busy input low before strobe blocks the write until busy high.
// - After busy releases, losing port holds strobe for the write-hold time.
// - Master/slave pin sets busy direction; slave busy inputs inhibit writes.
package dpb_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // Timing figures in ns, and derived cycle counts (least times round up)
  localparam int T_WP_NS = 12;
  localparam int T_WZ_NS = 10;
  localparam int T_DW_NS = 10;
  localparam int T_WH_NS = 12;
  localparam int T_BDD_NS = 18;
  localparam int T_SWRD_NS = 5;
  localparam int T_AS_NS = 0;
  localparam int T_WR_NS = 0;
  localparam int T_AA_NS = 15;
  function automatic int cyc_up(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 : (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  localparam int WP_CYC = cyc_up(T_WP_NS);
  localparam int WP_OE_CYC = cyc_up(T_WZ_NS + T_DW_NS > T_WP_NS ? T_WZ_NS + T_DW_NS : T_WP_NS);
  localparam int WH_CYC = cyc_up(T_WH_NS);
  localparam int BDD_CYC = cyc_up(T_BDD_NS);
  localparam int SWRD_CYC = cyc_up(T_SWRD_NS);
  localparam int AS_CYC = cyc_up(T_AS_NS);
  localparam int WR_CYC = cyc_up(T_WR_NS);
  localparam int RD_CYC = cyc_up(T_AA_NS);
  localparam int CNT_W = 4;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] SEM_FREE = 8'h01;
  typedef enum logic [6:0] {
    DPB_IDLE  = 7'h01,
    DPB_SETUP = 7'h02,
    DPB_PULSE = 7'h04,
    DPB_HOLD  = 7'h08,
    DPB_READ  = 7'h10,
    DPB_SWRD  = 7'h20,
    DPB_RECOV = 7'h40
  } dpb_state_t;
endpackage

/* rtl/dpb_cnt_if.sv */
// Interface between the sequencer and its delay counter.
// Assumes one clock domain.
`timescale 1ns/1ps
interface dpb_cnt_if;
  import dpb_pkg::*;
  logic load;
  logic [CNT_W-1:0] value;
  logic done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

/* rtl/dpb_timer.sv */
// Down counter that times each phase of a port cycle.
// Load may stay high for several cycles (busy on a read); the counter reloads on each.
`timescale 1ns/1ps
module dpb_timer
  import dpb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  dpb_cnt_if.tmr cnt
);
  logic [CNT_W-1:0] cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (cnt.load) begin
      cnt_q <= cnt.value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Done must not depend on load: the sequencer derives load from done
  assign cnt.done = (cnt_q == '0);
endmodule

/* bench/dpb_dev_model.sv */
// Behavioural model of one port of the dual-port memory with its semaphore flags.
// Assumes pins change just after rising edges; busy_cmd_i and other_hold_i stand in for the far port.
`timescale 1ns/1ps
module dpb_dev_model
  import dpb_pkg::*;
(
  input wire logic clk_i,
  input wire logic master_i,
  input wire logic cs_n_i,
  input wire logic sem_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] din_i,
  input wire logic busy_cmd_i,
  input wire logic other_hold_i,
  output logic [DATA_W-1:0] dout_o,
  output logic busy_n_o,
  output logic drive_o
);
  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic [7:0] sem_q = 8'hff;
  logic [DATA_W-1:0] last_q = 8'h00;
  logic [DATA_W-1:0] rd_val;
  // Far port on the same address: busy follows our select in master mode
  assign busy_n_o = master_i ? !(busy_cmd_i && !cs_n_i) : !busy_cmd_i;
  // No output drive once the strobe is low
  assign drive_o = !oe_n_i && we_n_i && (!cs_n_i || !sem_n_i);
  assign rd_val = cs_n_i ? {7'h7f, sem_q[addr_i[2:0]]} : mem_q[addr_i];
  // A released bus shows the inverse of the last value
  assign dout_o = drive_o ? rd_val : ~last_q;
  always @(posedge clk_i) begin
    if (drive_o) last_q <= rd_val;
    if (!cs_n_i && sem_n_i && !we_n_i && busy_n_o) mem_q[addr_i] <= din_i;
    if (cs_n_i && !sem_n_i && !we_n_i && !(other_hold_i && !din_i[0])) sem_q[addr_i[2:0]] <= din_i[0];
  end
endmodule

/* bench/tb.sv */
// Self-checking bench for the port controller against the memory model.
// Assumes a 200 MHz clock; inputs change on falling edges.
`timescale 1ns/1ps
module tb;
  import dpb_pkg::*;
  logic clk = 0, rst = 1, req = 0, rw = 0, rs = 0, ro = 0, master = 1, busy_cmd = 0, other_hold = 0;
  logic [ADDR_W-1:0] radr = '0, adr, pa = '0;
  logic [DATA_W-1:0] rwd = '0, din, rdata, dout;
  logic busy_n, ready, done, grant, cs_n, sem_n, we_n, oe_n, doe, drive, saw = 0;
  logic [9:0] notes[$];
  logic [9:0] nt;
  logic [7:0] d [4];
  logic [13:0] a [4];
  int num_errors = 0, cmp_count = 0, seed = 30, wlen = 0, hlen = 0;
  dpb_port_ctl uut (.CLOCK_I(clk), .RST_I(rst), .REQ_I(req), .REQ_WRITE_I(rw), .REQ_SEM_I(rs),
    .REQ_OE_LOW_I(ro), .REQ_ADDR_I(radr), .REQ_WDATA_I(rwd), .MASTER_I(master), .BUSY_N_I(busy_n),
    .DATA_I(din), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata), .SEM_GRANT_O(grant),
    .CHIP_SEL_N_O(cs_n), .SEMAPHORE_SELECT_N_O(sem_n), .WRITE_N_O(we_n), .OUT_EN_N_O(oe_n),
    .ADDR_O(adr), .DATA_O(dout), .DATA_OE_O(doe));
  dpb_dev_model dev (.clk_i(clk), .master_i(master), .cs_n_i(cs_n), .sem_n_i(sem_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .addr_i(adr), .din_i(doe ? dout : ~dout), .busy_cmd_i(busy_cmd), .other_hold_i(other_hold),
    .dout_o(din), .busy_n_o(busy_n), .drive_o(drive));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Entered and left at a falling edge; the note is the expected result
  task automatic acc(input logic w, s, o, input logic [13:0] ad, input logic [7:0] wd, input logic [9:0] n);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    {req, rw, rs, ro, radr, rwd} = {1'b1, w, s, o, ad, wd};
    notes.push_back(n);
    @(negedge clk);
    req = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 200) begin
      num_errors++;
      end_of_test;
    end
  endtask
  always @(negedge clk) begin
    if (done === 1'b1) begin
      nt = notes.size() > 0 ? notes.pop_front() : 10'h3ff;
      if (nt[9:8] == 2'd1) chk("rdata", nt[7:0], rdata);
      else if (nt[9:8] == 2'd2) chk("sem_grant", nt[7:0], {7'h00, grant});
      else if (nt[9:8] == 2'd3) chk("note_queue", 8'h00, 8'h01);
    end
  end
  always @(negedge clk) begin
    if (!rst) begin
      chk("sel_pair", 8'h01, {7'h00, cs_n | sem_n});
      chk("bus_fight", 8'h00, {7'h00, doe & drive});
      chk("addr_move", 8'h00, {7'h00, adr !== pa && !we_n && !(cs_n && sem_n)});
      pa = adr;
      if (!we_n) begin
        wlen++;
        if (!busy_n) begin
          saw = 1;
          hlen = 0;
        end else hlen++;
      end else if (wlen > 0) begin
        chk("wp_len", 8'h01, {7'h00, wlen >= (ro ? WP_OE_CYC : WP_CYC)});
        // Busy changes on a falling edge, so the hold also spans the half cycle after the last count
        if (saw) chk("wh_len", 8'h01, {7'h00, 2 * hlen * CLK_PERIOD_NS + CLK_PERIOD_NS >= 2 * T_WH_NS});
        wlen = 0;
        saw = 0;
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (int i = 0; i < 4; i++) begin
      a[i] = 14'(($random(seed) << 2) | i);
      d[i] = 8'($random(seed));
      acc(1'b1, 1'b0, i[0], a[i], d[i], 10'h000);
    end
    for (int i = 0; i < 4; i++) acc(1'b0, 1'b0, 1'b1, a[i], 8'h00, {2'd1, d[i]});
    acc(1'b1, 1'b1, 1'b0, 14'h0003, 8'h00, {2'd2, 8'h01});
    acc(1'b1, 1'b1, 1'b0, 14'h0003, 8'h01, {2'd2, 8'h00});
    other_hold = 1;
    acc(1'b1, 1'b1, 1'b0, 14'h0005, 8'h00, {2'd2, 8'h00});
    other_hold = 0;
    for (int m = 0; m < 2; m++) begin
      master = !m[0];
      busy_cmd <= 1;
      fork
        acc(1'b1, 1'b0, 1'b0, a[m], ~d[m], 10'h000);
        begin
          repeat (8) @(negedge clk);
          busy_cmd <= 0;
        end
      join
      acc(1'b0, 1'b0, 1'b1, a[m], 8'h00, {2'd1, ~d[m]});
    end
    // Let the checker take the last note before the verdict
    @(negedge clk);
    chk("notes_left", 8'h00, 8'(notes.size()));
    end_of_test;
  end
endmodule
